// ===== src/ctm_pkg.sv
/*
 * package for the compact 10-bit timer: register indices, field positions,
 * reset values, mode codes and carrier structs.
 * assumes a byte-wide register port with one-cycle read latency.
 */
package ctm_pkg;
   // ----------------------------------------
   // register indices
   // ----------------------------------------
   localparam logic [2:0] CTRL0_IDX   = 3'h0;
   localparam logic [2:0] CTRL1_IDX   = 3'h1;
   localparam logic [2:0] CNT_LO_IDX  = 3'h2;
   localparam logic [2:0] CNT_HI_IDX  = 3'h3;
   localparam logic [2:0] CMPA_LO_IDX = 3'h4;
   localparam logic [2:0] CMPA_HI_IDX = 3'h5;
   localparam logic [2:0] FLAGS_IDX   = 3'h6;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int C0_PAUSE = 7;
   localparam int C0_ON    = 3;
   localparam int C1_OINIT = 3;
   localparam int C1_OINV  = 2;
   localparam int C1_SWAP  = 1;
   localparam int C1_CCLR  = 0;
   localparam int FL_A     = 0;
   localparam int FL_P     = 1;
   localparam int CNT_W    = 10;
   localparam int PER_W    = 3;
   localparam int PER_LSB  = 7;
   localparam logic [7:0]       REG_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
   localparam logic [CNT_W:0]   PER_UNIT = 11'h080;
   // ----------------------------------------
   // codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'h0,
      CTM_MODE_UND = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TMR = 2'h3
   } ctm_mode_e;
   localparam logic [1:0] OF_NONE = 2'h0;
   localparam logic [1:0] OF_LOW  = 2'h1;
   localparam logic [1:0] OF_HIGH = 2'h2;
   localparam logic [1:0] OF_TOG  = 2'h3;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ctm_bus_s;
   typedef struct packed {
      logic [7:0]       ctrl0;
      logic [7:0]       ctrl1;
      logic [CNT_W-1:0] cmpa;
      logic [CNT_W-1:0] cnt;
      logic             flag_a;
      logic             flag_p;
      logic             pin;
      logic             on_d;
      logic [7:0]       rdata;
   } ctm_state_s;
endpackage

// ===== src/ctm_timer.sv
/*
 * compact 10-bit timer with compare A and 3-bit period comparator,
 * compare-output, pwm and timer/counter modes.
 * assumes COUNT_TICK is a one-cycle pulse already in the SYS_CLK domain
 * (clock source selection lives outside) and a byte register port.
 */
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer (
   // clock and reset
   input  wire logic       SYS_CLK,
   input  wire logic       SYS_RST,
   // count enable from clock selector
   input  wire logic       COUNT_TICK,
   // register port
   input  wire logic [2:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA,
   // events
   output logic            MATCH_A_PULSE,
   output logic            MATCH_P_PULSE,
   // output pin
   output logic            TP_OUT,
   output logic            TP_OE
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam int W = ctm_pkg::CNT_W;
   ctm_pkg::ctm_state_s st_reg;
   ctm_pkg::ctm_state_s st_next;
   ctm_pkg::ctm_bus_s   bus;
   ctm_pkg::ctm_mode_e  mode;
   logic [1:0]   ofunc;
   logic [2:0]   per_field;
   logic         on, pause, cclr, swap, oinit, oinv;
   logic         tick, cmp_a, cmp_p, ovf, clr, set_a, set_p;
   logic [W:0]   per_len, duty_len, cnt_x;
   logic         pwm_act, pwm_lvl;

   assign bus       = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
   assign mode      = ctm_pkg::ctm_mode_e'(st_reg.ctrl1[7:6]);
   assign ofunc     = st_reg.ctrl1[5:4];
   assign per_field = st_reg.ctrl0[2:0];
   assign on        = st_reg.ctrl0[ctm_pkg::C0_ON];
   assign pause     = st_reg.ctrl0[ctm_pkg::C0_PAUSE];
   assign cclr      = st_reg.ctrl1[ctm_pkg::C1_CCLR];
   assign swap      = st_reg.ctrl1[ctm_pkg::C1_SWAP];
   assign oinit     = st_reg.ctrl1[ctm_pkg::C1_OINIT];
   assign oinv      = st_reg.ctrl1[ctm_pkg::C1_OINV];

   // ----------------------------------------
   // comparators
   // ----------------------------------------
   // pause freezes count
   assign tick  = on & ~pause & COUNT_TICK;
   // period vs top three bits
   // low bits all ones too, else the match would last a whole 128-count block
   assign cmp_p = tick & (per_field != 3'h0)
                & (st_reg.cnt[W-1:ctm_pkg::PER_LSB] + 3'h1 == per_field)
                & (&st_reg.cnt[ctm_pkg::PER_LSB-1:0]);
   assign cmp_a = tick & (st_reg.cmpa != '0) & (st_reg.cnt + 10'h001 == st_reg.cmpa);
   assign ovf   = tick & (st_reg.cnt == ctm_pkg::CNT_MAX);
   // period length in counts, zero field means full 1024
   assign per_len = (per_field == 3'h0) ? 11'h400 : 11'(per_field * ctm_pkg::PER_UNIT);

   always_comb begin
      if (mode == ctm_pkg::CTM_MODE_PWM) begin
         if (!swap) begin
            clr   = cmp_p | ((per_field == 3'h0) & ovf);
            set_a = cmp_a;
            set_p = cmp_p | ((per_field == 3'h0) & ovf);
         end else begin
            clr   = cmp_a | ovf;
            set_a = cmp_a;
            set_p = cmp_p;
         end
      end else if (cclr) begin
         // clear on A, no P flag
         clr   = cmp_a | ovf;
         set_a = cmp_a;
         set_p = 1'b0;
      end else begin
         clr   = cmp_p | ((per_field == 3'h0) & ovf);
         set_a = cmp_a;
         set_p = cmp_p | ((per_field == 3'h0) & ovf);
      end
   end

   // ----------------------------------------
   // pwm waveform
   // ----------------------------------------
   assign cnt_x = {1'b0, st_reg.cnt};
   // field is period, A is duty
   // A is period, field is duty
   assign duty_len = swap ? per_len : {1'b0, st_reg.cmpa};
   // duty at or beyond period stays active
   assign pwm_act  = (cnt_x < duty_len);
   always_comb begin
      unique case (ofunc)
         2'h0:    pwm_lvl = ~oinit;
         2'h1:    pwm_lvl = oinit;
         2'h2:    pwm_lvl = pwm_act ? oinit : ~oinit;
         default: pwm_lvl = ~oinit;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.on_d  = on;
      st_next.rdata = ctm_pkg::REG_RST;
      // counter
      if (on & ~st_reg.on_d) begin
         st_next.cnt = '0;
      end else if (tick) begin
         st_next.cnt = clr ? '0 : st_reg.cnt + 10'h001;
      end
      if (set_a) st_next.flag_a = 1'b1;
      if (set_p) st_next.flag_p = 1'b1;
      // pwm pin first: a forced level must not be overridden by the on edge
      if (mode == ctm_pkg::CTM_MODE_PWM) begin
         st_next.pin = pwm_lvl;
      end else if (on & ~st_reg.on_d) begin
         st_next.pin = oinit;
      end else if (set_a && mode == ctm_pkg::CTM_MODE_CMP) begin
         unique case (ofunc)
            ctm_pkg::OF_NONE: st_next.pin = st_reg.pin;
            ctm_pkg::OF_LOW:  st_next.pin = 1'b0;
            ctm_pkg::OF_HIGH: st_next.pin = 1'b1;
            ctm_pkg::OF_TOG:  st_next.pin = ~st_reg.pin;
         endcase
      end
      // register writes; flags write-one-to-clear, set wins
      if (bus.wr) begin
         unique case (bus.addr)
            ctm_pkg::CTRL0_IDX:   st_next.ctrl0 = bus.wdata;
            ctm_pkg::CTRL1_IDX:   st_next.ctrl1 = bus.wdata;
            ctm_pkg::CMPA_LO_IDX: st_next.cmpa[7:0] = bus.wdata;
            ctm_pkg::CMPA_HI_IDX: st_next.cmpa[W-1:8] = bus.wdata[1:0];
            ctm_pkg::FLAGS_IDX: begin
               if (bus.wdata[ctm_pkg::FL_A] && !set_a) st_next.flag_a = 1'b0;
               if (bus.wdata[ctm_pkg::FL_P] && !set_p) st_next.flag_p = 1'b0;
            end
            default: ;
         endcase
      end
      // reads; unmapped reads zero
      if (bus.rd) begin
         unique case (bus.addr)
            ctm_pkg::CTRL0_IDX:   st_next.rdata = st_reg.ctrl0;
            ctm_pkg::CTRL1_IDX:   st_next.rdata = st_reg.ctrl1;
            ctm_pkg::CNT_LO_IDX:  st_next.rdata = st_reg.cnt[7:0];
            ctm_pkg::CNT_HI_IDX:  st_next.rdata = {6'h00, st_reg.cnt[W-1:8]};
            ctm_pkg::CMPA_LO_IDX: st_next.rdata = st_reg.cmpa[7:0];
            ctm_pkg::CMPA_HI_IDX: st_next.rdata = {6'h00, st_reg.cmpa[W-1:8]};
            ctm_pkg::FLAGS_IDX:   st_next.rdata = {6'h00, st_reg.flag_p, st_reg.flag_a};
            default:              st_next.rdata = ctm_pkg::REG_RST;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign REG_RDATA     = st_reg.rdata;
   assign MATCH_A_PULSE = set_a;
   assign MATCH_P_PULSE = set_p;
   assign TP_OE  = (mode == ctm_pkg::CTM_MODE_CMP) | (mode == ctm_pkg::CTM_MODE_PWM);
   assign TP_OUT = TP_OE & (st_reg.pin ^ oinv);
endmodule
`default_nettype wire

// ===== testbench/ctm_far_side.sv
/* far side model: count clock source and pin load.
   assumes ticks are already in the SYS_CLK domain. */
`timescale 1ns/1ps
`default_nettype none
module ctm_far_side (
   // clock and control
   input  wire logic SYS_CLK,
   input  wire logic tick_en,
   // timer pins
   input  wire logic TP_OUT,
   input  wire logic TP_OE,
   output logic      COUNT_TICK,
   output logic      pin_level
);
   always_ff @(posedge SYS_CLK) begin
      COUNT_TICK <= tick_en;
   end
   assign pin_level = TP_OE ? TP_OUT : 1'b0;
endmodule
`default_nettype wire

// ===== testbench/ctm_timer_assertions.sv
/* checker for the timer ports, with control writes shadowed.
   assumes binding onto ctm_timer. */
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_chk (
   // clock and reset
   input wire logic       SYS_CLK,
   input wire logic       SYS_RST,
   // register port
   input wire logic [2:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_RDATA,
   // events and pin
   input wire logic       MATCH_A_PULSE,
   input wire logic       MATCH_P_PULSE,
   input wire logic       TP_OUT,
   input wire logic       TP_OE
);
   // ----
   // shadow registers
   // ----
   logic [7:0] sh_reg [8];
   logic [1:0] md;
   assign md = sh_reg[1][7:6];
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) sh_reg <= '{default: 8'h00};
      else if (REG_WR) sh_reg[REG_ADDR] <= REG_WDATA;
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // writes move the pin legally, so look only at quiet stretches
   sequence s_quiet;
      !REG_WR && !$past(REG_WR) && !$past(REG_WR, 2);
   endsequence
   sequence s_on_rise;
      $rose(sh_reg[0][3]) && md == 2'h0;
   endsequence
   AST_RD_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data outside read slot");
   AST_NO_P: assert property (sh_reg[1][0] && md != 2'h2 |-> !MATCH_P_PULSE)
      else $error("p match with clear select high");
   AST_NO_A: assert property ({sh_reg[5][1:0], sh_reg[4]} == 10'h000 |-> !MATCH_A_PULSE)
      else $error("a match with compare zero");
   AST_STOP: assert property (!sh_reg[0][3] || sh_reg[0][7] |-> !MATCH_A_PULSE && !MATCH_P_PULSE)
      else $error("match while stopped");
   AST_PIN_A: assert property (s_quiet ##0 (md == 2'h0 && $changed(TP_OUT)) |-> $past(MATCH_A_PULSE))
      else $error("pin moved without a match");
   AST_ON_INIT: assert property (s_on_rise |=> TP_OUT == (sh_reg[1][3] ^ sh_reg[1][2]))
      else $error("pin not at initial level");
   AST_OE_TMR: assert property (md == 2'h3 |-> !TP_OE && !TP_OUT)
      else $error("pin driven in timer mode");
   AST_FORCE: assert property (md == 2'h2 && !sh_reg[1][5] && $stable(sh_reg[1])
      |-> TP_OUT == ((sh_reg[1][4] ~^ sh_reg[1][3]) ^ sh_reg[1][2]))
      else $error("forced pwm level wrong");
endmodule
bind ctm_timer ctm_timer_chk ctm_timer_chk_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MATCH_A_PULSE(MATCH_A_PULSE),
   .MATCH_P_PULSE(MATCH_P_PULSE), .TP_OUT(TP_OUT), .TP_OE(TP_OE));
`default_nettype wire

// ===== testbench/tb.sv
/* bench for the timer: registers, compare, timer and pwm modes.
   assumes the far side model gives a tick every clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0, ten = 1, pin, tick, mo, moe, pa, pp;
   logic [2:0] adr = 3'h0;
   logic [7:0] wd = 8'h00, rdat, d;
   int err_count = 0, compares = 0, ca, cp, hi;
   logic [7:0] c1t [5] = '{8'h31, 8'h21, 8'h19, 8'h09, 8'hC1};
   int cht [5] = '{15, 30, 0, 30, 0};
   logic [7:0] p1 [6] = '{8'hA8, 8'hA8, 8'hAC, 8'hAA, 8'h88, 8'h98};
   logic [9:0] pat [6] = '{10'h020, 10'h0C8, 10'h020, 10'h12C, 10'h020, 10'h020};
   int pl [6] = '{128, 128, 128, 300, 128, 128};
   int ph [6] = '{32, 128, 96, 128, 0, 128};
   int pc [6] = '{1, 0, 1, 1, 1, 1};
   ctm_timer ctm_timer_i (.SYS_CLK(clk), .SYS_RST(rst), .COUNT_TICK(tick), .REG_ADDR(adr), .REG_WDATA(wd),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .MATCH_A_PULSE(pa), .MATCH_P_PULSE(pp), .TP_OUT(mo), .TP_OE(moe));
   ctm_far_side ctm_far_side_i (.SYS_CLK(clk), .tick_en(ten), .TP_OUT(mo), .TP_OE(moe), .COUNT_TICK(tick),
      .pin_level(pin));
   initial forever #12.5 clk = ~clk;
   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk) begin adr <= a; wd <= v; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk) begin adr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 v = rdat;
   endtask
   task automatic run(input int n);
      ca = 0; cp = 0; hi = 0;
      repeat (n) begin
         @(negedge clk);
         ca += pa; cp += pp; hi += pin;
      end
   endtask
   task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
      wreg(3'h0, 8'h00); wreg(3'h1, c1); wreg(3'h4, a[7:0]); wreg(3'h5, {6'h00, a[9:8]}); wreg(3'h0, c0);
      run(6);
   endtask
   task automatic t_regs;
      for (int i = 0; i < 8; i++) begin
         rreg(i[2:0], d);
         `CHK("reset value", 8'h00, d)
      end
      wreg(3'h5, 8'hFF); rreg(3'h5, d);
      `CHK("compare high", 8'h03, d)
      wreg(3'h2, 8'hFF); rreg(3'h2, d);
      `CHK("count low", 8'h00, d)
      $display("test regs done");
   endtask
   task automatic t_cmp;
      for (int i = 0; i < 5; i++) begin
         cfg(c1t[i], 10'h003, 8'h08);
         run(30);
         `CHK("a hits", 10, ca)
         `CHK("p hits", 0, cp)
         `CHK("pin high", cht[i], hi)
      end
      $display("test compare done");
   endtask
   task automatic t_period;
      cfg(8'h00, 10'h003, 8'h09);
      run(256);
      `CHK("a hits", 2, ca)
      `CHK("p hits", 2, cp)
      wreg(3'h0, 8'h89); run(20);
      `CHK("paused hits", 0, ca + cp)
      rreg(3'h6, d);
      `CHK("flags", 8'h03, d)
      wreg(3'h6, 8'h01); rreg(3'h6, d);
      `CHK("flags cleared", 8'h02, d)
      wreg(3'h0, 8'h09); run(256);
      `CHK("resumed hits", 2, ca)
      cfg(8'h00, 10'h000, 8'h08);
      run(1024);
      `CHK("overflow a", 0, ca)
      `CHK("overflow p", 1, cp)
      $display("test period done");
   endtask
   task automatic t_pwm;
      for (int i = 0; i < 6; i++) begin
         cfg(p1[i], pat[i], 8'h09);
         run(pl[i]);
         `CHK("pwm high", ph[i], hi)
         `CHK("pwm a", pc[i], ca)
         `CHK("pwm p", 1, cp)
      end
      $display("test pwm done");
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_cmp;
      t_period;
      t_pwm;
      test_done;
   end
endmodule
`default_nettype wire
